/* File: bench/can_acceptance_filter_bank_tb.sv */
// self-checking bench for the acceptance filter bank
`timescale 1ns/1ps
module can_acceptance_filter_bank_tb
  import acc_filter_pkg::*;
();
  logic clock, rstn, reg_wr, reg_rd, rx_valid, rx_sid12, rx_ext, payload_mode, accept_valid;
  logic [1:0] reg_sel;
  logic [4:0] reg_index, accept_fifo, accept_filter;
  logic [31:0] reg_wdata, reg_rdata, dir;
  logic [10:0] rx_sid;
  logic [17:0] rx_eid, rx_data18;
  logic [31:0] head [num_fifos];
  logic [31:0] tail [num_fifos];
  int error_cnt = 0;
  int check_count = 0;
  acc_filter_bank DUT (.clock(clock), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
    .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .config_mode(1'b0),
    .queue_direction_select(dir), .fifo_head_addr(head), .fifo_tail_addr(tail), .rx_valid(rx_valid),
    .rx_sid(rx_sid), .rx_sid12(rx_sid12), .rx_eid(rx_eid), .rx_data18(rx_data18), .rx_ext(rx_ext),
    .payload_mode(payload_mode), .accept_valid(accept_valid), .accept_fifo(accept_fifo),
    .accept_filter(accept_filter));
  can_frame_source src (.clock(clock), .rx_valid(rx_valid), .rx_sid(rx_sid), .rx_sid12(rx_sid12),
    .rx_eid(rx_eid), .rx_data18(rx_data18), .rx_ext(rx_ext));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] s, input logic [4:0] i, input logic [31:0] d);
    @(negedge clock);
    {reg_wr, reg_sel, reg_index, reg_wdata} = {1'b1, s, i, d};
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] s, input logic [4:0] i, input logic [31:0] e);
    @(negedge clock);
    {reg_rd, reg_sel, reg_index} = {1'b1, s, i};
    @(negedge clock);
    reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask : rd
  task automatic frm(input logic e, input logic [10:0] s, input logic [17:0] x, input logic [17:0] d,
                     input logic v, input logic [4:0] f, input logic [4:0] n);
    src.send(e, s, x, d);
    chk(32'(accept_valid), 32'(v));
    if (v) begin
      chk(32'(accept_fifo), 32'(f));
      chk(32'(accept_filter), 32'(n));
    end
  endtask : frm
  task automatic t_regs();
    rd(sel_ctrl, 5'h00, reg_reset);
    rd(sel_mask, 5'h1F, reg_reset);
    rd(sel_ctrl, 5'h08, 32'h00000000);
    wr(sel_obj, 5'h03, 32'hFFFFFFFF);
    wr(sel_mask, 5'h03, 32'hFFFFFFFF);
    rd(sel_obj, 5'h03, 32'h7FFFFFFF);
    rd(sel_mask, 5'h03, 32'h7FFFFFFF);
    wr(sel_ctrl, 5'h00, 32'hFFFFFFFF);
    rd(sel_ctrl, 5'h00, 32'h9F9F9F9F);
    wr(sel_obj, 5'h03, 32'h00000000);
    rd(sel_obj, 5'h03, 32'h7FFFFFFF);
    wr(sel_ctrl, 5'h00, 32'h81818181);
    rd(sel_ctrl, 5'h00, 32'h9F9F9F9F);
    wr(sel_ctrl, 5'h00, 32'h00000000);
    rd(sel_ctrl, 5'h00, 32'h1F1F1F1F);
    wr(sel_ctrl, 5'h00, 32'h00000000);
    rd(sel_ctrl, 5'h00, 32'h00000000);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_match();
    wr(sel_obj, 5'h05, 32'h00000123);
    wr(sel_mask, 5'h05, 32'h400007FF);
    wr(sel_obj, 5'h06, 32'h00000123);
    wr(sel_mask, 5'h06, 32'h000007FF);
    wr(sel_ctrl, 5'h01, 32'h00898700);
    frm(1'b0, 11'h123, 18'h00000, 18'h00000, 1'b1, 5'h07, 5'h05);
    frm(1'b0, 11'h124, 18'h00000, 18'h00000, 1'b0, 5'h00, 5'h00);
    frm(1'b1, 11'h123, 18'h3FFFF, 18'h00000, 1'b1, 5'h09, 5'h06);
    wr(sel_ctrl, 5'h01, 32'h00890700);
    frm(1'b0, 11'h123, 18'h00000, 18'h00000, 1'b1, 5'h09, 5'h06);
    $display("t_match done");
  endtask : t_match
  task automatic t_payload();
    wr(sel_obj, 5'h02, 32'h15555000);
    wr(sel_mask, 5'h02, 32'h1FFFF800);
    wr(sel_ctrl, 5'h00, 32'h00840000);
    payload_mode = 1'b1;
    frm(1'b0, 11'h000, 18'h15555, 18'h2AAAA, 1'b1, 5'h04, 5'h02);
    frm(1'b0, 11'h000, 18'h2AAAA, 18'h2AAAB, 1'b0, 5'h00, 5'h00);
    payload_mode = 1'b0;
    $display("t_payload done");
  endtask : t_payload
  task automatic t_uaddr();
    rd(sel_uaddr, 5'h05, 32'hA0000005);
    rd(sel_uaddr, 5'h06, 32'hB0000006);
    wr(sel_uaddr, 5'h06, 32'hFFFFFFFF);
    rd(sel_uaddr, 5'h06, 32'hB0000006);
    $display("t_uaddr done");
  endtask : t_uaddr
  initial begin
    {rstn, reg_wr, reg_rd, payload_mode, reg_sel, reg_index, reg_wdata} = '0;
    dir = 32'h00000020;
    for (int i = 0; i < num_fifos; i++) begin
      head[i] = 32'hA0000000 + 32'(i);
      tail[i] = 32'hB0000000 + 32'(i);
    end
    repeat (8) @(negedge clock);
    rstn = 1'b1;
    t_regs();
    t_match();
    t_payload();
    t_uaddr();
    end_sim();
  end
  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end
endmodule : can_acceptance_filter_bank_tb

/* File: bench/can_frame_source.sv */
// frame source standing in for remote bus nodes
`timescale 1ns/1ps
module can_frame_source (
  input wire logic clock,
  output logic rx_valid,
  output logic [10:0] rx_sid,
  output logic rx_sid12,
  output logic [17:0] rx_eid,
  output logic [17:0] rx_data18,
  output logic rx_ext
);
  initial begin
    rx_valid = 1'b0;
    {rx_ext, rx_sid12, rx_sid, rx_eid, rx_data18} = '0;
  end
  // one frame for one cycle, then fields scrambled
  task automatic send(input logic e, input logic [10:0] s, input logic [17:0] x, input logic [17:0] d);
    @(negedge clock);
    rx_valid = 1'b1;
    {rx_ext, rx_sid12, rx_sid, rx_eid, rx_data18} = {e, 1'b0, s, x, d};
    @(negedge clock);
    rx_valid = 1'b0;
    {rx_ext, rx_sid12, rx_sid, rx_eid, rx_data18} = ~{e, 1'b0, s, x, d};
  endtask : send
endmodule : can_frame_source

/* File: hdl/acc_filter_bank.sv */
`timescale 1ns/1ps
// acceptance filter bank with per-fifo user address readout
module acc_filter_bank
  import acc_filter_pkg::*;
#(
  parameter int nfilt = num_filters
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_sel,
  input wire logic [4:0] reg_index,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic config_mode,
  input wire logic [31:0] queue_direction_select,
  input wire logic [31:0] fifo_head_addr [num_fifos],
  input wire logic [31:0] fifo_tail_addr [num_fifos],
  input wire logic rx_valid,
  input wire logic [10:0] rx_sid,
  input wire logic rx_sid12,
  input wire logic [17:0] rx_eid,
  input wire logic [17:0] rx_data18,
  input wire logic rx_ext,
  input wire logic payload_mode,
  output logic accept_valid,
  output logic [4:0] accept_fifo,
  output logic [4:0] accept_filter
);
  logic [31:0] filter_control [num_ctrl_words];
  logic [31:0] filter_object [num_filters];
  logic [31:0] acceptance_mask [num_filters];
  logic [num_filters-1:0] slot_en;
  logic [4:0] slot_ptr [num_filters];
  logic [num_filters-1:0] hit_vec;
  logic [2:0] ctrl_idx;
  logic wr_ctrl;
  logic wr_obj;
  logic wr_mask;
  logic [31:0] rd_mux;
  logic [31:0] queue_ram_pointer;
  logic any_hit;
  logic [4:0] first_hit;

  // lowest numbered hit wins
  function automatic logic [4:0] first_set(input logic [num_filters-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = num_filters - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : first_set

  assign ctrl_idx = reg_index[2:0];
  assign wr_ctrl = reg_wr && (reg_sel == sel_ctrl) && (reg_index < 5'(num_ctrl_words));
  // object and mask only writable while the slot is disabled
  assign wr_obj = reg_wr && (reg_sel == sel_obj) && !slot_en[reg_index];
  assign wr_mask = reg_wr && (reg_sel == sel_mask) && !slot_en[reg_index];

  genvar g;
  generate
    for (g = 0; g < num_filters; g++) begin : g_slot
      assign slot_en[g] = filter_control[g / 4][8 * (g % 4) + slot_en_pos];
      assign slot_ptr[g] = filter_control[g / 4][8 * (g % 4) + slot_ptr_msb -: 5];
      filter_compare u_cmp (
        .filt(filter_object[g]),
        .mask(acceptance_mask[g]),
        .rx_sid(rx_sid),
        .rx_sid12(rx_sid12),
        .rx_eid(rx_eid),
        .rx_data18(rx_data18),
        .rx_ext(rx_ext),
        .payload_mode(payload_mode),
        .enable(slot_en[g]),
        .hit(hit_vec[g])
      );
    end
  endgenerate

  generate
    for (g = 0; g < num_ctrl_words; g++) begin : g_ctrl
      logic [31:0] nxt;
      always_comb begin
        nxt = filter_control[g];
        for (int s = 0; s < 4; s++) begin
          // enable always writable, pointer only while enable held at 0
          nxt[8 * s + slot_en_pos] = reg_wdata[8 * s + slot_en_pos];
          if (!filter_control[g][8 * s + slot_en_pos]) begin
            nxt[8 * s +: 5] = reg_wdata[8 * s +: 5];
          end
        end
      end
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          filter_control[g] <= reg_reset;
        end else if (wr_ctrl && ctrl_idx == 3'(g)) begin
          filter_control[g] <= nxt & {4{slot_wmask}};
        end
      end
    end
    for (g = 0; g < num_filters; g++) begin : g_obj
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          filter_object[g] <= reg_reset;
          acceptance_mask[g] <= reg_reset;
        end else begin
          if (wr_obj && reg_index == 5'(g)) begin
            filter_object[g] <= reg_wdata & obj_wmask;
          end
          if (wr_mask && reg_index == 5'(g)) begin
            acceptance_mask[g] <= reg_wdata & obj_wmask;
          end
        end
      end
    end
  endgenerate

  // head for transmit, tail for receive
  assign queue_ram_pointer = queue_direction_select[reg_index] ? fifo_head_addr[reg_index]
                                                               : fifo_tail_addr[reg_index];
  always_comb begin
    if (reg_sel == sel_ctrl) begin
      rd_mux = (reg_index < 5'(num_ctrl_words)) ? filter_control[ctrl_idx] : 32'h00000000;
    end else if (reg_sel == sel_obj) begin
      rd_mux = filter_object[reg_index];
    end else if (reg_sel == sel_mask) begin
      rd_mux = acceptance_mask[reg_index];
    end else begin
      rd_mux = queue_ram_pointer;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  assign any_hit = |hit_vec;
  assign first_hit = first_set(hit_vec);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      accept_valid <= 1'b0;
      accept_fifo <= 5'h00;
      accept_filter <= 5'h00;
    end else begin
      // reserved pointer never routes a frame
      accept_valid <= rx_valid && any_hit && (slot_ptr[first_hit] != ptr_reserved);
      if (rx_valid && any_hit) begin
        accept_fifo <= slot_ptr[first_hit];
        accept_filter <= first_hit;
      end
    end
  end

  // last register access, held one cycle for the write checks
  logic [4:0] last_index_r;
  logic [31:0] last_object_r;
  logic [31:0] last_mask_r;
  logic [31:0] last_wdata_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      last_index_r <= 5'h00;
      last_object_r <= 32'h00000000;
      last_mask_r <= 32'h00000000;
      last_wdata_r <= 32'h00000000;
    end else begin
      last_index_r <= reg_index;
      last_object_r <= filter_object[reg_index];
      last_mask_r <= acceptance_mask[reg_index];
      last_wdata_r <= reg_wdata;
    end
  end

  // frame whose lowest numbered hit filter has a usable pointer
  sequence s_frame_hit;
    rx_valid && any_hit && (slot_ptr[first_hit] != ptr_reserved);
  endsequence

  // result of that frame one cycle later
  sequence s_routed;
    accept_valid && (accept_fifo == $past(slot_ptr[first_hit])) && (accept_filter == $past(first_hit));
  endsequence

  property p_route;
    @(posedge clock) disable iff (!rstn)
    s_frame_hit |=> s_routed;
  endproperty
  a_route: assert property (p_route) else $error("hit not routed");
  property p_no_hit;
    @(posedge clock) disable iff (!rstn)
    (!rx_valid || hit_vec == '0) |=> !accept_valid;
  endproperty
  a_no_hit: assert property (p_no_hit) else $error("accept without hit");
  property p_dis_nohit;
    @(posedge clock) disable iff (!rstn)
    (hit_vec & ~slot_en) == '0;
  endproperty
  a_dis_nohit: assert property (p_dis_nohit) else $error("disabled filter hit");
  property p_obj_lock;
    @(posedge clock) disable iff (!rstn)
    (reg_wr && reg_sel == sel_obj && slot_en[reg_index]) |=> (filter_object[last_index_r] == last_object_r);
  endproperty
  a_obj_lock: assert property (p_obj_lock) else $error("enabled object changed");
  property p_mask_lock;
    @(posedge clock) disable iff (!rstn)
    (reg_wr && reg_sel == sel_mask && slot_en[reg_index]) |=> (acceptance_mask[last_index_r] == last_mask_r);
  endproperty
  a_mask_lock: assert property (p_mask_lock) else $error("enabled mask changed");
  property p_ptr_lock;
    @(posedge clock) disable iff (!rstn)
    (slot_en[0] && $stable(slot_en[0])) |-> $stable(slot_ptr[0]);
  endproperty
  a_ptr_lock: assert property (p_ptr_lock) else $error("pointer changed while enabled");
  property p_rsvd;
    @(posedge clock) disable iff (!rstn)
    filter_object[0][31] == 1'b0 && acceptance_mask[0][31] == 1'b0 && filter_control[0][6:5] == 2'b00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_uaddr;
    @(posedge clock) disable iff (!rstn)
    (reg_rd && reg_sel == sel_uaddr) |=>
      reg_rdata == ($past(queue_direction_select[reg_index]) ? $past(fifo_head_addr[reg_index])
                                                             : $past(fifo_tail_addr[reg_index]));
  endproperty
  a_uaddr: assert property (p_uaddr) else $error("user address wrong");

  // lowest numbered hit is the one reported
  property p_first_hit;
    @(posedge clock) disable iff (!rstn)
    any_hit |-> (hit_vec[first_hit] && ((hit_vec & ((32'h00000001 << first_hit) - 32'h00000001)) == 32'h00000000));
  endproperty
  a_first_hit: assert property (p_first_hit) else $error("lowest hit not chosen");

  // enable bits always take the written value
  property p_enable_write;
    @(posedge clock) disable iff (!rstn)
    wr_ctrl |=> ((filter_control[last_index_r[2:0]] & 32'h80808080) == (last_wdata_r & 32'h80808080));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable bit not written");

  // writes to a disabled object land, top bit dropped
  property p_obj_write;
    @(posedge clock) disable iff (!rstn)
    wr_obj |=> (filter_object[last_index_r] == (last_wdata_r & obj_wmask));
  endproperty
  a_obj_write: assert property (p_obj_write) else $error("object write lost");

  // writes to a disabled mask land, top bit dropped
  property p_mask_write;
    @(posedge clock) disable iff (!rstn)
    wr_mask |=> (acceptance_mask[last_index_r] == (last_wdata_r & obj_wmask));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  // control index beyond the bank reads zero
  property p_ctrl_oob;
    @(posedge clock) disable iff (!rstn)
    (reg_rd && reg_sel == sel_ctrl && reg_index >= 5'h08) |=> (reg_rdata == 32'h00000000);
  endproperty
  a_ctrl_oob: assert property (p_ctrl_oob) else $error("missing control word not zero");

  // read data stands until the next read
  property p_rdata_hold;
    @(posedge clock) disable iff (!rstn)
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  // routing result stands until the next hit
  property p_fields_hold;
    @(posedge clock) disable iff (!rstn)
    !(rx_valid && any_hit) |=> ($stable(accept_fifo) && $stable(accept_filter));
  endproperty
  a_fields_hold: assert property (p_fields_hold) else $error("routing result moved");

  // an accept always follows a presented frame
  property p_accept_cause;
    @(posedge clock) disable iff (!rstn)
    accept_valid |-> $past(rx_valid);
  endproperty
  a_accept_cause: assert property (p_accept_cause) else $error("accept without frame");

  generate
    for (g = 0; g < num_filters; g++) begin : g_lock
      // pointer frozen while the slot stays enabled
      property p_slot_ptr_lock;
        @(posedge clock) disable iff (!rstn)
        (slot_en[g] && $past(slot_en[g])) |-> $stable(slot_ptr[g]);
      endproperty
      a_slot_ptr_lock: assert property (p_slot_ptr_lock) else $error("slot pointer changed while enabled");

      // unimplemented top bit reads zero
      property p_top_bits;
        @(posedge clock) disable iff (!rstn)
        !filter_object[g][31] && !acceptance_mask[g][31];
      endproperty
      a_top_bits: assert property (p_top_bits) else $error("object or mask top bit set");

      // disabled slot never hits
      property p_disabled_quiet;
        @(posedge clock) disable iff (!rstn)
        !slot_en[g] |-> !hit_vec[g];
      endproperty
      a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled slot hit");
    end

    for (g = 0; g < num_ctrl_words; g++) begin : g_ctrl_chk
      // gap bits between enable and pointer read zero
      property p_ctrl_gaps;
        @(posedge clock) disable iff (!rstn)
        (filter_control[g] & ~{4{slot_wmask}}) == 32'h00000000;
      endproperty
      a_ctrl_gaps: assert property (p_ctrl_gaps) else $error("control gap bit set");
    end
  endgenerate
endmodule : acc_filter_bank

/* File: hdl/filter_compare.sv */
`timescale 1ns/1ps
// one filter/mask comparator
module filter_compare
  import acc_filter_pkg::*;
(
  input wire logic [31:0] filt,
  input wire logic [31:0] mask,
  input wire logic [10:0] rx_sid,
  input wire logic rx_sid12,
  input wire logic [17:0] rx_eid,
  input wire logic [17:0] rx_data18,
  input wire logic rx_ext,
  input wire logic payload_mode,
  input wire logic enable,
  output wire logic hit
);
  wire [31:0] rx_word;
  wire type_ok;
  wire bits_ok;
  // payload mode puts first data bits where eid sits
  assign rx_word = {1'b0, rx_ext, rx_sid12, (payload_mode ? rx_data18 : rx_eid), rx_sid};
  // masked bits must match, bit 30 handled as type check
  assign bits_ok = (((rx_word ^ filt) & mask & 32'h3FFFFFFF) == 32'h00000000);
  assign type_ok = !mask[type_pos] || (filt[type_pos] == rx_ext);
  assign hit = enable && bits_ok && type_ok;
endmodule : filter_compare

/* File: pkg/acc_filter_pkg.sv */
// constants and layouts for the acceptance filter bank
// Function
// - transmit queue address reads ram head
// - receive queue address reads ram tail
// - eight control words, four slots each
// - only enabled filters take part
// - hit routes frame to pointed fifo
// - pointer changes only while slot disabled
// - 32 filter objects, writable only disabled
// - object fields: sid, eid, bit twelve, type
// - type select picks extended or standard
// - type enforce bit gates type check
// - 32 masks paired with filter objects
// - mask mirrors filter layout, bit31 zero
// - payload mode compares eid with data
// - payload mode masks first data bits
// - all filter bits zero after reset
// - user address read-only, 32 bits
// - direction bit picks head or tail
package acc_filter_pkg;
  localparam int num_filters = 32;
  localparam int num_ctrl_words = 8;
  localparam int num_fifos = 32;
  localparam int sid_lsb = 0;
  localparam int sid_msb = 10;
  localparam int eid_lsb = 11;
  localparam int eid_msb = 28;
  localparam int sid12_pos = 29;
  localparam int type_pos = 30;
  localparam int slot_en_pos = 7;
  localparam int slot_ptr_msb = 4;
  localparam logic [31:0] obj_wmask = 32'h7FFFFFFF;
  localparam logic [7:0] slot_wmask = 8'h9F;
  localparam logic [31:0] reg_reset = 32'h00000000;
  localparam logic [4:0] ptr_reserved = 5'h00;
  localparam logic [1:0] sel_ctrl = 2'h0;
  localparam logic [1:0] sel_obj = 2'h1;
  localparam logic [1:0] sel_mask = 2'h2;
  localparam logic [1:0] sel_uaddr = 2'h3;
  typedef enum logic [1:0] {
    mt_idle = 2'b00,
    mt_scan = 2'b01,
    mt_done = 2'b11
  } match_state_t;
endpackage : acc_filter_pkg
